// file: wtu_top.sv
`timescale 1ns/1ps
`default_nettype none
module wtu_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  // rc oscillator
  input  wire logic        rc_osc_clk,
  // option bits and core status
  input  wire logic        always_on_option,
  input  wire logic        timeout_response_option,
  input  wire logic        stop_mode,
  input  wire logic        debug_mode,
  input  wire logic        watchdog_refresh_instruction,
  // other reset sources
  input  wire logic        ext_reset_event,
  input  wire logic        pin_stop_recovery_event,
  // register access
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  // requests and status
  output logic             irq_req,
  output logic             short_reset_req,
  output logic             stop_recovery_req,
  output logic             wdt_running,
  output logic      [7:0]  watchdog_control_status
);

  // ==========================================================
  // oscillator tick
  logic osc_tick;

  wtu_osc_tick u_tick (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .osc_in  (rc_osc_clk),
    .tick    (osc_tick)
  );

  // ==========================================================
  // register decode
  logic        wr_ctrl;
  logic        wr_upper;
  logic        wr_high;
  logic        wr_low;
  logic        rd_ctrl;
  assign wr_ctrl  = reg_wr && (reg_addr == wtu_pkg::ADDR_CTRL);
  assign wr_upper = reg_wr && (reg_addr == wtu_pkg::ADDR_UPPER);
  assign wr_high  = reg_wr && (reg_addr == wtu_pkg::ADDR_HIGH);
  assign wr_low   = reg_wr && (reg_addr == wtu_pkg::ADDR_LOW);
  assign rd_ctrl  = reg_rd && (reg_addr == wtu_pkg::ADDR_CTRL);

  // ==========================================================
  // unlock sequence
  wtu_pkg::wtu_lock_t lock_reg;
  wtu_pkg::wtu_lock_t lock_next;
  logic               take_upper;
  logic               take_high;
  logic               take_low;

  assign take_upper = wr_upper && (lock_reg == wtu_pkg::LOCK_GOT_2);
  assign take_high  = wr_high  && (lock_reg == wtu_pkg::LOCK_GOT_U);
  assign take_low   = wr_low   && (lock_reg == wtu_pkg::LOCK_GOT_H);

  always_comb begin
    lock_next = lock_reg;
    if (reg_wr) begin
      case (lock_reg)
        wtu_pkg::LOCK_GOT_1: begin
          if (wr_ctrl && reg_wdata == wtu_pkg::UNLOCK_2) begin
            lock_next = wtu_pkg::LOCK_GOT_2;
          end else begin
            lock_next = wtu_pkg::LOCK_IDLE;
          end
        end
        wtu_pkg::LOCK_GOT_2: begin
          lock_next = take_upper ? wtu_pkg::LOCK_GOT_U : wtu_pkg::LOCK_IDLE;
        end
        wtu_pkg::LOCK_GOT_U: begin
          lock_next = take_high ? wtu_pkg::LOCK_GOT_H : wtu_pkg::LOCK_IDLE;
        end
        default: begin
          lock_next = wtu_pkg::LOCK_IDLE;
        end
      endcase
      // a fresh first key always restarts the sequence
      if (wr_ctrl && reg_wdata == wtu_pkg::UNLOCK_1) begin
        lock_next = wtu_pkg::LOCK_GOT_1;
      end
    end
  end

  // ==========================================================
  // reload value
  logic [7:0]  rld_upper_reg;
  logic [7:0]  rld_high_reg;
  logic [7:0]  rld_low_reg;
  logic [23:0] reload_value;
  assign reload_value = {rld_upper_reg, rld_high_reg, rld_low_reg};

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lock_reg      <= wtu_pkg::LOCK_IDLE;
      rld_upper_reg <= wtu_pkg::RELOAD_RST[23:16];
      rld_high_reg  <= wtu_pkg::RELOAD_RST[15:8];
      rld_low_reg   <= wtu_pkg::RELOAD_RST[7:0];
    end else begin
      lock_reg <= lock_next;
      if (take_upper) begin
        rld_upper_reg <= reg_wdata;
      end
      if (take_high) begin
        rld_high_reg <= reg_wdata;
      end
      if (take_low) begin
        rld_low_reg <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // down counter
  logic [23:0] count_reg;
  logic [23:0] count_next;
  logic        run_reg;
  logic        enable_req;
  logic        first_enable;
  logic        refresh_ok;
  logic        timeout_hit;

  assign enable_req   = watchdog_refresh_instruction || always_on_option;
  assign first_enable = !run_reg && enable_req;
  assign refresh_ok   = watchdog_refresh_instruction &&
                        (count_reg > wtu_pkg::COUNT_LOCK);
  assign timeout_hit  = run_reg && !debug_mode && osc_tick &&
                        (count_reg == wtu_pkg::COUNT_ONE);

  always_comb begin
    count_next = count_reg;
    if (first_enable || (run_reg && (debug_mode || refresh_ok))) begin
      count_next = reload_value;
    end else if (run_reg && osc_tick) begin
      if (count_reg == wtu_pkg::COUNT_ZERO) begin
        count_next = wtu_pkg::COUNT_MAX;
      end else begin
        count_next = count_reg - wtu_pkg::COUNT_ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= wtu_pkg::RELOAD_RST;
      run_reg   <= 1'b0;
    end else begin
      count_reg <= count_next;
      if (enable_req) begin
        run_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // time-out event stage into the system domain
  logic evt_reg;
  logic evt_stop_reg;
  logic evt_irq_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      evt_reg      <= 1'b0;
      evt_stop_reg <= 1'b0;
      evt_irq_reg  <= 1'b0;
    end else begin
      evt_reg      <= timeout_hit;
      evt_stop_reg <= stop_mode;
      evt_irq_reg  <= !timeout_response_option;
    end
  end

  // ==========================================================
  // status flags, set wins over read clear
  logic flag_por_reg;
  logic flag_stop_reg;
  logic flag_tout_reg;
  logic flag_ext_reg;
  logic clr_tout_ext;
  assign clr_tout_ext = rd_ctrl || pin_stop_recovery_event;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      flag_por_reg  <= 1'b1;
      flag_stop_reg <= 1'b0;
      flag_tout_reg <= 1'b0;
      flag_ext_reg  <= 1'b0;
    end else begin
      if (evt_reg || rd_ctrl || pin_stop_recovery_event) begin
        flag_por_reg <= 1'b0;
      end
      if (pin_stop_recovery_event) begin
        flag_stop_reg <= 1'b1;
      end else if (evt_reg) begin
        flag_stop_reg <= evt_stop_reg;
      end else if (rd_ctrl) begin
        flag_stop_reg <= 1'b0;
      end
      if (evt_reg) begin
        flag_tout_reg <= 1'b1;
      end else if (clr_tout_ext) begin
        flag_tout_reg <= 1'b0;
      end
      if (ext_reset_event) begin
        flag_ext_reg <= 1'b1;
      end else if (clr_tout_ext) begin
        flag_ext_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // requests and read data
  logic [7:0] ctrl_value;
  logic [7:0] rdata_next;

  assign ctrl_value = {flag_por_reg, flag_stop_reg, flag_tout_reg,
                       flag_ext_reg, 4'h0};
  assign rdata_next =
    (reg_addr == wtu_pkg::ADDR_CTRL)  ? ctrl_value :
    (reg_addr == wtu_pkg::ADDR_UPPER) ? count_reg[23:16] :
    (reg_addr == wtu_pkg::ADDR_HIGH)  ? count_reg[15:8] :
    (reg_addr == wtu_pkg::ADDR_LOW)   ? count_reg[7:0] : 8'h00;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata               <= 8'h00;
      irq_req                 <= 1'b0;
      short_reset_req         <= 1'b0;
      stop_recovery_req       <= 1'b0;
      wdt_running             <= 1'b0;
      watchdog_control_status <= 8'h00;
    end else begin
      reg_rdata         <= reg_rd ? rdata_next : 8'h00;
      irq_req           <= evt_reg && evt_irq_reg;
      short_reset_req   <= evt_reg && !evt_irq_reg && !evt_stop_reg;
      stop_recovery_req <= evt_reg && evt_stop_reg;
      wdt_running       <= run_reg;
      watchdog_control_status <= ctrl_value;
    end
  end

endmodule
`default_nettype wire

// file: wtu_pkg.sv
package wtu_pkg;

  // ==========================================================
  // register addresses
  localparam logic [11:0] ADDR_CTRL   = 12'h0ff0;
  localparam logic [11:0] ADDR_UPPER  = 12'h0ff1;
  localparam logic [11:0] ADDR_HIGH   = 12'h0ff2;
  localparam logic [11:0] ADDR_LOW    = 12'h0ff3;

  // ==========================================================
  // control/status field positions
  localparam int          BIT_POR     = 7;
  localparam int          BIT_STOP    = 6;
  localparam int          BIT_TOUT    = 5;
  localparam int          BIT_EXT     = 4;

  // ==========================================================
  // values and reset values
  localparam logic [7:0]  UNLOCK_1    = 8'h55;
  localparam logic [7:0]  UNLOCK_2    = 8'haa;
  localparam logic [23:0] RELOAD_RST  = 24'hff_ffff;
  localparam logic [23:0] COUNT_MAX   = 24'hff_ffff;
  localparam logic [23:0] COUNT_LOCK  = 24'h00_0002;
  localparam logic [23:0] COUNT_ONE   = 24'h00_0001;
  localparam logic [23:0] COUNT_ZERO  = 24'h00_0000;
  localparam logic [23:0] RELOAD_MIN  = 24'h00_0004;

  // ==========================================================
  // timing
  localparam int          OSC_FREQ_HZ = 50000;
  localparam int          SYS_FREQ_HZ = 25000000;

  // ==========================================================
  // unlock sequence states
  typedef enum logic [2:0] {
    LOCK_IDLE,
    LOCK_GOT_1,
    LOCK_GOT_2,
    LOCK_GOT_U,
    LOCK_GOT_H
  } wtu_lock_t;

endpackage

// file: wtu_osc_tick.sv
`timescale 1ns/1ps
`default_nettype none
module wtu_osc_tick (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic arst_n,
  // oscillator level in, tick out
  input  wire logic osc_in,
  output logic      tick
);

  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      // start high: a pin resting high gives no false edge after reset
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
      prev_reg  <= 1'b1;
    end else begin
      sync1_reg <= osc_in;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // one pulse per rising oscillator edge
  assign tick = sync2_reg & ~prev_reg;

endmodule
`default_nettype wire

// file: wtu_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module wtu_osc_model #(
  parameter int HALF_NS = 330
) (
  input  wire logic run,
  output logic      rc_osc_clk
);
  // ==========
  // rc oscillator, held still while not enabled
  initial rc_osc_clk = 1'b0;
  always #HALF_NS if (run) rc_osc_clk = ~rc_osc_clk;
endmodule
`default_nettype wire

// file: wtu_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module wtu_top_asserts (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       arst_n,
  // options
  input wire logic       timeout_response_option,
  input wire logic       stop_mode,
  input wire logic       debug_mode,
  // requests and status
  input wire logic       irq_req,
  input wire logic       short_reset_req,
  input wire logic       stop_recovery_req,
  input wire logic       wdt_running,
  input wire logic [7:0] watchdog_control_status
);
  // ==========
  // properties
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_irq_one_cycle: assert property (irq_req |=> !irq_req)
    else $error("irq request longer than one cycle");
  a_irq_response: assert property (irq_req |-> !timeout_response_option)
    else $error("irq request with reset response");
  a_reset_normal: assert property (short_reset_req |->
    timeout_response_option && !stop_mode)
    else $error("short reset in wrong mode");
  a_stop_irq_pair: assert property (stop_recovery_req &&
    !timeout_response_option |-> irq_req)
    else $error("stop recovery without irq");
  a_stop_only: assert property (stop_recovery_req |-> stop_mode)
    else $error("stop recovery outside stop mode");
  a_stop_flags: assert property (stop_recovery_req |=>
    watchdog_control_status[wtu_pkg::BIT_STOP] &&
    watchdog_control_status[wtu_pkg::BIT_TOUT])
    else $error("stop time-out flags missing");
  a_tout_flag: assert property (irq_req || short_reset_req |=>
    watchdog_control_status[wtu_pkg::BIT_TOUT])
    else $error("time-out flag missing");
  a_never_off: assert property (wdt_running |=> wdt_running)
    else $error("watchdog turned off");
  a_debug_quiet: assert property (debug_mode [*4] |->
    !irq_req && !short_reset_req && !stop_recovery_req)
    else $error("time-out in debug mode");
  c_irq: cover property (irq_req && !stop_mode);
  c_reset: cover property (short_reset_req);
  c_stop: cover property (stop_recovery_req && irq_req);
endmodule
bind wtu_top wtu_top_asserts u_chk (.clk_sys, .arst_n,
  .timeout_response_option, .stop_mode, .debug_mode, .irq_req,
  .short_reset_req, .stop_recovery_req, .wdt_running,
  .watchdog_control_status);
`default_nettype wire

// file: test_wtu_top.sv
`timescale 1ns/1ps
`default_nettype none
module test_wtu_top;
  // ==========
  // stimulus and dut
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  logic        run     = 1'b0;
  logic        aon     = 1'b0;
  logic        opt     = 1'b0;
  logic        stp     = 1'b0;
  logic        dbg     = 1'b0;
  logic        ref_p   = 1'b0;
  logic        ext_p   = 1'b0;
  logic        pin_p   = 1'b0;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [11:0] addr    = 12'h0000;
  logic [7:0]  wd      = 8'h00;
  logic        rc_osc_clk, irq, srst, srec, runs;
  logic [7:0]  rdat, stat;
  logic [2:0]  seen;
  int          waited;
  int          fail_count = 0;
  int          checks = 0;
  always #20 clk_sys = ~clk_sys;
  wtu_osc_model osc (.run(run), .rc_osc_clk(rc_osc_clk));
  wtu_top dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .rc_osc_clk(rc_osc_clk), .always_on_option(aon),
    .timeout_response_option(opt), .stop_mode(stp), .debug_mode(dbg),
    .watchdog_refresh_instruction(ref_p), .ext_reset_event(ext_p),
    .pin_stop_recovery_event(pin_p), .reg_addr(addr), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdat), .irq_req(irq),
    .short_reset_req(srst), .stop_recovery_req(srec),
    .wdt_running(runs), .watchdog_control_status(stat));
  // ==========
  // shared tasks
  task automatic chk(input string what, input logic [23:0] s, e);
    checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s exp %h seen %h", what, e, s);
    end
  endtask
  task automatic wrb(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(negedge clk_sys);
    wr = 1'b0;
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    addr = a;
    rd = 1'b1;
    @(negedge clk_sys);
    rd = 1'b0;
    chk("read", rdat, e);
  endtask
  task automatic refresh();
    @(negedge clk_sys);
    ref_p = 1'b1;
    @(negedge clk_sys);
    ref_p = 1'b0;
  endtask
  task automatic unlock(input logic [7:0] k, u, h, l);
    wrb(wtu_pkg::ADDR_CTRL, wtu_pkg::UNLOCK_1);
    wrb(wtu_pkg::ADDR_CTRL, k);
    wrb(wtu_pkg::ADDR_UPPER, u);
    wrb(wtu_pkg::ADDR_HIGH, h);
    wrb(wtu_pkg::ADDR_LOW, l);
  endtask
  task automatic wait_req();
    seen = 3'b000;
    waited = 0;
    run = 1'b1;
    while (waited < 5000 && seen == 3'b000) begin
      @(negedge clk_sys);
      waited++;
      seen = {irq, srst, srec};
    end
    run = 1'b0;
    repeat (2) begin
      @(negedge clk_sys);
      seen = seen | {irq, srst, srec};
    end
  endtask
  task automatic reset_dut(input logic ao);
    @(negedge clk_sys);
    arst_n = 1'b0;
    aon = ao;
    stp = 1'b0;
    opt = 1'b0;
    repeat (4) @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (2) @(negedge clk_sys);
  endtask
  // ==========
  // scenarios
  task automatic regs();
    chk("status", stat, 8'h80);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h80);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h00);
    rdchk(wtu_pkg::ADDR_UPPER, 8'hff);
    rdchk(12'h0123, 8'h00);
    unlock(wtu_pkg::UNLOCK_2, 8'h00, 8'h01, 8'h04);
    unlock(8'h12, 8'h01, 8'h01, 8'h01);
    chk("running", runs, 1'b0);
    refresh();
    @(negedge clk_sys);
    chk("running", runs, 1'b1);
    rdchk(wtu_pkg::ADDR_UPPER, 8'h00);
    rdchk(wtu_pkg::ADDR_HIGH, 8'h01);
    rdchk(wtu_pkg::ADDR_LOW, 8'h04);
  endtask
  task automatic ev(input logic e, p);
    @(negedge clk_sys);
    ext_p = e;
    pin_p = p;
    @(negedge clk_sys);
    ext_p = 1'b0;
    pin_p = 1'b0;
  endtask
  task automatic events();
    ev(1'b1, 1'b0);
    wrb(wtu_pkg::ADDR_CTRL, wtu_pkg::UNLOCK_1);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h10);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h00);
    ev(1'b1, 1'b0);
    ev(1'b0, 1'b1);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h40);
    rdchk(wtu_pkg::ADDR_CTRL, 8'h00);
  endtask
  task automatic modes();
    for (int i = 0; i < 4; i++) begin
      opt = i[0];
      stp = i[1];
      refresh();
      rdchk(wtu_pkg::ADDR_LOW, 8'h04);
      wait_req();
      chk("requests", seen, {~i[0], i[0] & ~i[1], i[1]});
      chk("period", waited > 4250 && waited < 4310, 1'b1);
      chk("status", stat, i[1] ? 8'h60 : 8'h20);
      rdchk(wtu_pkg::ADDR_CTRL, i[1] ? 8'h60 : 8'h20);
      refresh();
      rdchk(wtu_pkg::ADDR_LOW, 8'h00);
      run = 1'b1;
      repeat (40) @(negedge clk_sys);
      run = 1'b0;
      rdchk(wtu_pkg::ADDR_UPPER, 8'hff);
    end
  endtask
  task automatic debug_hold();
    dbg = 1'b1;
    refresh();
    wait_req();
    chk("debug", seen, 3'b000);
    rdchk(wtu_pkg::ADDR_LOW, 8'h04);
    dbg = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    reset_dut(1'b0);
    regs();
    events();
    modes();
    debug_hold();
    reset_dut(1'b1);
    chk("always on", runs, 1'b1);
    rdchk(wtu_pkg::ADDR_UPPER, 8'hff);
    complete_run();
  end
  initial begin
    #3_000_000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
